// [rtl/spindle_phase_error_monitor.sv]
// Function
// - In spindle sync mode with R-command sync or shift request, the first register shows the error including the stored shift offset.
// - Both degree registers count one degree per least significant step.
// - In spindle sync mode the degree registers update only while both spindles run at constant speed.
// - In polygon phase sync the degree registers show the error for the commanded shift amount.
// - In spindle sync mode the second register shows the error with the stored shift offset removed.
// - In polygon phase sync the second degree register equals the first.
// - While phase sync control is active the monitor register shows the error in encoder pulses.
// - A register holds the lowest pulse error seen during phase sync control.
// - A register holds the highest pulse error seen during phase sync control.
// - Before a spindle has passed its index pulse the degree registers read minus one whenever they update, the pulse register only with a sync or shift request.
//
// Strobed register access and the address map are this design's own decisions.
`include "phase_mon_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module spindle_phase_error_monitor
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire phase_mon_pkg::phase_in_t i_phase,
	input wire phase_mon_pkg::reg_req_t i_req,
	output logic [15:0] o_rdata,
	output logic o_deg_valid,
	output logic o_sync_active
);

	// synchronised copies of the mode levels (they come from another block's pins)
	logic [5:0] lvl_meta_r;
	logic [5:0] lvl_r;
	// data words registered two stages deep beside the levels
	logic signed [15:0] deg_total_r;
	logic signed [15:0] shift_r;
	logic signed [15:0] pulses_r;

	// registers
	logic signed [15:0] err_with_shift_r;
	logic signed [15:0] err_without_shift_r;
	logic signed [15:0] err_pulses_r;
	logic [5:0] mode_stat_r;
	phase_mon_pkg::mode_t mode_r;
	phase_mon_pkg::mode_t mode_nxt;
	logic limit_clear;
	logic sample_limits;
	logic signed [15:0] lower_w;
	logic signed [15:0] upper_w;
	logic limits_valid;
	logic deg_update;
	logic phase_ok;
	logic spindle_req;

	// saturating signed subtract, used for offset removal
	function automatic logic signed [15:0] sat_sub(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		if (d > 17'sh0_7fff)
			sat_sub = 16'sh7fff;
		else if (d < -17'sh0_8000)
			sat_sub = 16'sh8000;
		else
			sat_sub = d[15:0];
	endfunction

	// two-stage synchroniser on the mode levels, data captured alongside
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			lvl_meta_r <= 6'h00;
			lvl_r <= 6'h00;
		end
		else
		begin
			lvl_meta_r <= {i_phase.index_seen, i_phase.speeds_constant, i_phase.r_sync_active,
				i_phase.phase_shift_calc_request, i_phase.polygon_phase_sync_mode,
				i_phase.spindle_sync_mode};
			lvl_r <= lvl_meta_r;
		end
	end

	// data words are held two stages deep so they line up with the levels
	logic signed [15:0] deg_meta_r;
	logic signed [15:0] shift_meta_r;
	logic signed [15:0] pulses_meta_r;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			deg_meta_r <= `RST_ERR;
			shift_meta_r <= `RST_ERR;
			pulses_meta_r <= `RST_ERR;
			deg_total_r <= `RST_ERR;
			shift_r <= `RST_ERR;
			pulses_r <= `RST_ERR;
		end
		else
		begin
			deg_meta_r <= i_phase.err_deg_total;
			shift_meta_r <= i_phase.shift_offset_deg;
			pulses_meta_r <= i_phase.err_pulses;
			deg_total_r <= deg_meta_r;
			shift_r <= shift_meta_r;
			pulses_r <= pulses_meta_r;
		end
	end

	// mode decode: polygon takes precedence if both levels are seen
	always_comb
	begin
		if (lvl_r[1])
			mode_nxt = phase_mon_pkg::MODE_POLYGON;
		else if (lvl_r[0])
			mode_nxt = phase_mon_pkg::MODE_SPINDLE;
		else
			mode_nxt = phase_mon_pkg::MODE_IDLE;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			mode_r <= phase_mon_pkg::MODE_IDLE;
		else
			mode_r <= mode_nxt;
	end

	// update qualification
	assign spindle_req = lvl_r[3] | lvl_r[2];
	assign phase_ok = lvl_r[5];
	assign deg_update = (mode_r == phase_mon_pkg::MODE_POLYGON) ||
		((mode_r == phase_mon_pkg::MODE_SPINDLE) && spindle_req && lvl_r[4]);
	// phase sync control active: index seen, in spindle mode with sync or in polygon mode
	assign sample_limits = phase_ok && ((mode_r == phase_mon_pkg::MODE_POLYGON) ||
		((mode_r == phase_mon_pkg::MODE_SPINDLE) && spindle_req));

	// degree error registers, one degree per step, signed 16 bits
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			err_with_shift_r <= `RST_ERR;
			err_without_shift_r <= `RST_ERR;
		end
		else if (deg_update)
		begin
			if (!phase_ok)
			begin
				err_with_shift_r <= `PHASE_UNKNOWN;
				err_without_shift_r <= `PHASE_UNKNOWN;
			end
			else
			begin
				unique case (mode_r)
					phase_mon_pkg::MODE_POLYGON:
					begin
						err_with_shift_r <= deg_total_r;
						err_without_shift_r <= deg_total_r;
					end
					phase_mon_pkg::MODE_SPINDLE:
					begin
						err_with_shift_r <= deg_total_r;
						err_without_shift_r <= sat_sub(deg_total_r, shift_r);
					end
					phase_mon_pkg::MODE_IDLE:
					begin
						err_with_shift_r <= err_with_shift_r;
						err_without_shift_r <= err_without_shift_r;
					end
				endcase
			end
		end
	end

	// pulse monitor, minus one while phase unknown in a sync mode with a sync or shift request
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			err_pulses_r <= `RST_ERR;
		else if (mode_r != phase_mon_pkg::MODE_IDLE && spindle_req && !phase_ok)
			err_pulses_r <= `PHASE_UNKNOWN;
		else if (sample_limits)
			err_pulses_r <= pulses_r;
	end

	// limits restart on entry to sync control or by software write
	logic sample_d_r;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			sample_d_r <= 1'b0;
		else
			sample_d_r <= sample_limits;
	end
	assign limit_clear = (sample_limits && !sample_d_r) ||
		(i_req.wr && i_req.addr == `REG_LIMIT_CLEAR);

	phase_limit_tracker u_phase_limit_tracker
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clear(limit_clear),
		.i_sample(sample_limits),
		.i_value(pulses_r),
		.o_lower(lower_w),
		.o_upper(upper_w),
		.o_valid(limits_valid)
	);

	// status word of the block's own state
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			mode_stat_r <= 6'h00;
		else
		begin
			mode_stat_r[`STAT_SPINDLE_SYNC] <= mode_r == phase_mon_pkg::MODE_SPINDLE;
			mode_stat_r[`STAT_POLYGON_SYNC] <= mode_r == phase_mon_pkg::MODE_POLYGON;
			mode_stat_r[`STAT_SHIFT_REQ] <= spindle_req;
			mode_stat_r[`STAT_PHASE_VALID] <= phase_ok;
			mode_stat_r[`STAT_DEG_VALID] <= mode_r != phase_mon_pkg::MODE_IDLE;
			mode_stat_r[`STAT_LIMITS_VALID] <= limits_valid;
		end
	end

	// read port, data in the cycle after the strobe only
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !i_req.rd)
			o_rdata <= `RD_UNMAPPED;
		else
		begin
			case (i_req.addr)
				`REG_ERR_WITH_SHIFT: o_rdata <= err_with_shift_r;
				`REG_ERR_WITHOUT_SHIFT: o_rdata <= err_without_shift_r;
				`REG_ERR_MON_PULSES: o_rdata <= err_pulses_r;
				`REG_ERR_LOWER: o_rdata <= lower_w;
				`REG_ERR_UPPER: o_rdata <= upper_w;
				`REG_MODE_STATUS: o_rdata <= {10'h000, mode_stat_r};
				default: o_rdata <= `RD_UNMAPPED;
			endcase
		end
	end

	// validity flags for software and status pins
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_deg_valid <= 1'b0;
			o_sync_active <= 1'b0;
		end
		else
		begin
			o_deg_valid <= mode_r != phase_mon_pkg::MODE_IDLE;
			o_sync_active <= sample_limits;
		end
	end

endmodule
`default_nettype wire

// [rtl/phase_mon_defs.svh]
`ifndef PHASE_MON_DEFS_SVH
`define PHASE_MON_DEFS_SVH

// register addresses (word indices on the plain register port)
`define REG_ERR_WITH_SHIFT 4'h0
`define REG_ERR_WITHOUT_SHIFT 4'h1
`define REG_ERR_MON_PULSES 4'h2
`define REG_ERR_LOWER 4'h3
`define REG_ERR_UPPER 4'h4
`define REG_MODE_STATUS 4'h5
`define REG_LIMIT_CLEAR 4'h6

// mode status field positions
`define STAT_SPINDLE_SYNC 0
`define STAT_POLYGON_SYNC 1
`define STAT_SHIFT_REQ 2
`define STAT_PHASE_VALID 3
`define STAT_DEG_VALID 4
`define STAT_LIMITS_VALID 5

// reset values and the phase-unknown value
`define RST_ERR 16'h0000
`define RST_LOWER 16'h7fff
`define RST_UPPER 16'h8000
`define PHASE_UNKNOWN 16'hffff
`define RD_UNMAPPED 16'h0000

// clock period in ns and settle time for the synchroniser
`define CLK_PERIOD_NS 5
`define SETTLE_NS 20
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/phase_mon_pkg.sv]
package phase_mon_pkg;

	// raw phase measurement fed in by the controller core
	typedef struct packed {
		logic spindle_sync_mode;
		logic polygon_phase_sync_mode;
		logic phase_shift_calc_request;
		logic r_sync_active;
		logic speeds_constant;
		logic index_seen;
		logic signed [15:0] err_deg_total;
		logic signed [15:0] shift_offset_deg;
		logic signed [15:0] err_pulses;
	} phase_in_t;

	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [2:0] {
		MODE_IDLE = 3'b001,
		MODE_SPINDLE = 3'b010,
		MODE_POLYGON = 3'b100
	} mode_t;

endpackage

// [rtl/phase_limit_tracker.sv]
`include "phase_mon_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// tracks lowest and highest pulse error seen while phase sync is active
module phase_limit_tracker
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic i_sample,
	input wire logic signed [15:0] i_value,
	output logic signed [15:0] o_lower,
	output logic signed [15:0] o_upper,
	output logic o_valid
);

	// minimum and maximum tracking; a clear that meets a sample restarts the window with it
	always_ff @(posedge i_clk)
	begin
		if (i_rst || (i_clear && !i_sample))
		begin
			o_lower <= `RST_LOWER;
			o_upper <= `RST_UPPER;
			o_valid <= 1'b0;
		end
		else if (i_clear)
		begin
			// sample wins over clear so no error value is lost
			o_lower <= i_value;
			o_upper <= i_value;
			o_valid <= 1'b1;
		end
		else if (i_sample)
		begin
			if (!o_valid || i_value < o_lower)
				o_lower <= i_value;
			if (!o_valid || i_value > o_upper)
				o_upper <= i_value;
			o_valid <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// [verification/spindle_phase_error_monitor_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// checks read data against inputs held steady
module spindle_phase_error_monitor_chk
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire phase_mon_pkg::phase_in_t i_phase,
	input wire phase_mon_pkg::reg_req_t i_req,
	input wire logic [15:0] o_rdata,
	input wire logic o_deg_valid,
	input wire logic o_sync_active
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic signed [16:0] dif;
	logic [15:0] rsel;
	// one-hot read select and unsaturated difference
	assign dif = 17'(i_phase.err_deg_total) - 17'(i_phase.shift_offset_deg);
	assign rsel = i_req.rd ? (16'h0001 << i_req.addr) : 16'h0000;
	sequence s_spin;
		(i_phase.spindle_sync_mode && !i_phase.polygon_phase_sync_mode
		&& i_phase.r_sync_active && i_phase.speeds_constant && $stable(i_phase))[*6];
	endsequence
	sequence s_poly;
		(i_phase.polygon_phase_sync_mode && i_phase.index_seen && $stable(i_phase))[*6];
	endsequence
	sequence s_lim;
		(o_sync_active && i_phase.index_seen && $stable(i_phase))[*6];
	endsequence
	property p_deg;
		(i_phase.spindle_sync_mode || i_phase.polygon_phase_sync_mode)[*6] |-> o_deg_valid;
	endproperty
	property p_with;
		s_spin ##0 (rsel[0] && i_phase.index_seen) |=> o_rdata == $past(i_phase.err_deg_total);
	endproperty
	property p_without;
		s_spin ##0 (rsel[1] && i_phase.index_seen && dif[16] == dif[15])
		|=> o_rdata == $past(dif[15:0]);
	endproperty
	property p_index;
		s_spin ##0 (rsel[0] && !i_phase.index_seen) |=> o_rdata == 16'hffff;
	endproperty
	property p_poly;
		s_poly ##0 (rsel[0] || rsel[1]) |=> o_rdata == $past(i_phase.err_deg_total);
	endproperty
	property p_pulse;
		s_spin ##0 (rsel[2] && i_phase.index_seen) |=> o_rdata == $past(i_phase.err_pulses);
	endproperty
	property p_low;
		s_lim ##0 rsel[3] |=> $signed(o_rdata) <= $past(i_phase.err_pulses);
	endproperty
	property p_up;
		s_lim ##0 rsel[4] |=> $signed(o_rdata) >= $past(i_phase.err_pulses);
	endproperty
	a_deg: assert property (p_deg) else $error("degree valid flag low");
	a_with: assert property (p_with) else $error("with-shift error wrong");
	a_without: assert property (p_without) else $error("without-shift error wrong");
	a_index: assert property (p_index) else $error("missing index not minus one");
	a_poly: assert property (p_poly) else $error("polygon error wrong");
	a_pulse: assert property (p_pulse) else $error("pulse error wrong");
	a_low: assert property (p_low) else $error("lower limit above sample");
	a_up: assert property (p_up) else $error("upper limit below sample");
endmodule
bind spindle_phase_error_monitor spindle_phase_error_monitor_chk u_chk
(
	.i_clk,
	.i_rst,
	.i_phase,
	.i_req,
	.o_rdata,
	.o_deg_valid,
	.o_sync_active
);
`default_nettype wire

// [verification/spindle_phase_error_monitor_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module spindle_phase_error_monitor_bench;
	logic i_clk;
	logic i_rst;
	phase_mon_pkg::phase_in_t ph;
	phase_mon_pkg::reg_req_t rq;
	logic [15:0] o_rdata;
	logic o_deg_valid;
	logic o_sync_active;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	spindle_phase_error_monitor u_spindle_phase_error_monitor
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_phase(ph),
		.i_req(rq),
		.o_rdata(o_rdata),
		.o_deg_valid(o_deg_valid),
		.o_sync_active(o_sync_active)
	);
	// clock
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// counts, verdict, stop
	task end_of_test;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errors = errors + 1;
			end_of_test();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// read strobe, data checked the cycle after
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_clk);
		rq.rd <= 1'b1;
		rq.addr <= a;
		@(posedge i_clk);
		rq.rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	task wr(input logic [3:0] a);
		@(posedge i_clk);
		rq.wr <= 1'b1;
		rq.addr <= a;
		rq.wdata <= 16'h5a5a;
		@(posedge i_clk);
		rq.wr <= 1'b0;
	endtask
	// flags, total, offset, pulses; then let it settle
	task st(input logic [5:0] f, input logic [15:0] t, input logic [15:0] o, input logic [15:0] p);
		@(posedge i_clk);
		ph <= {f, t, o, p};
		repeat (8) @(posedge i_clk);
	endtask
	initial
	begin
		i_rst = 1'b1;
		ph = '0;
		rq = '0;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(4'h3, 16'h7fff);
		rd(4'h4, 16'h8000);
		st(6'h27, 16'hfffb, 16'h0003, 16'hffec);
		rd(4'h0, 16'hfffb);
		rd(4'h1, 16'hfff8);
		rd(4'h2, 16'hffec);
		chk({15'h0000, o_deg_valid}, 16'h0001);
		chk({15'h0000, o_sync_active}, 16'h0001);
		rd(4'h5, 16'h003d);
		st(6'h2b, 16'h000a, 16'h0004, 16'h0005);
		rd(4'h0, 16'h000a);
		rd(4'h1, 16'h0006);
		rd(4'h2, 16'h0005);
		rd(4'h3, 16'hffec);
		rd(4'h4, 16'h0005);
		wr(4'h6);
		st(6'h2b, 16'h000a, 16'h0004, 16'hfffd);
		rd(4'h3, 16'hfffd);
		rd(4'h4, 16'h0005);
		st(6'h29, 16'h0007, 16'h0004, 16'hfffd);
		rd(4'h0, 16'h000a);
		wr(4'h0);
		rd(4'h1, 16'h0006);
		st(6'h26, 16'h0007, 16'h0004, 16'h0001);
		rd(4'h0, 16'hffff);
		rd(4'h1, 16'hffff);
		rd(4'h2, 16'hffff);
		st(6'h11, 16'h001e, 16'h0009, 16'h0000);
		rd(4'h0, 16'h001e);
		rd(4'h1, 16'h001e);
		rd(4'h5, 16'h003a);
		rd(4'hf, 16'h0000);
		st(6'h00, 16'h0000, 16'h0000, 16'h0000);
		chk({15'h0000, o_deg_valid}, 16'h0000);
		chk({15'h0000, o_sync_active}, 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
